// [hw/ccx_char_unit.sv]
// Character select and insert unit on the six six-bit characters of a word.
`timescale 1ns/1ps
`default_nettype none
module ccx_char_unit
   import ccx_pkg::*;
(
   // Operands
   input  wire logic [WORD_W-1:0] asm_i,
   input  wire logic [2:0]        idx_i,
   input  wire logic [CHAR_W-1:0] new_char_i,
   // Results
   output logic [CHAR_W-1:0]      sel_char_o,
   output logic [WORD_W-1:0]      asm_ins_o
);

   logic [CHAR_W-1:0] pick [0:6];

   assign pick[0] = '0;

   // ==========================================================
   // Character one is the top six bits, character six the bottom six.
   for (genvar k = 1; k <= 6; k++) begin : g_char
      localparam int LSB = WORD_W - CHAR_W * k;
      logic hit;
      assign hit = (idx_i == 3'(k));
      assign pick[k] = pick[k-1] | (hit ? asm_i[LSB +: CHAR_W] : '0);
      assign asm_ins_o[LSB +: CHAR_W] = hit ? new_char_i : asm_i[LSB +: CHAR_W];
   end

   assign sel_char_o = pick[6];

endmodule
`default_nettype wire

// [hw/ccx_exec.sv]
// Channel control command executor with storage port and register slave.
`timescale 1ns/1ps
`default_nettype none
module ccx_exec
   import ccx_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   // Register bus
   input  wire logic [4:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   output logic [31:0]            avs_readdata_o,
   output logic                   avs_waitrequest_o,
   // Core storage
   output logic                   mem_req_o,
   output logic                   mem_we_o,
   output logic [ADDR_W-1:0]      mem_addr_o,
   output logic [WORD_W-1:0]      mem_wdata_o,
   input  wire logic              mem_ack_i,
   input  wire logic [WORD_W-1:0] mem_rdata_i,
   // Channel status
   output logic [5:0]             mode_ind_o,
   output logic                   busy_o
);

   ccx_mem_if mif ();

   ccx_state_t        state_reg;
   ccx_state_t        state_next;
   logic [ADDR_W-1:0] cmd_cnt_reg;
   logic [ADDR_W-1:0] addr_cnt_reg;
   logic [WC_W-1:0]   word_cnt_reg;
   logic [WORD_W-1:0] op_reg;
   logic [WORD_W-1:0] data_reg;
   logic [WORD_W-1:0] asm_reg;
   logic [WORD_W-1:0] ind_word_reg;
   logic              ind_done_reg;
   logic [5:0]        ctl_cnt_reg;
   logic [5:0]        check_reg;
   logic [ADDR_W-1:0] start_addr_reg;
   logic              unsup_reg;
   logic              stop_pend_reg;

   logic              mdone;
   logic              wr_hit;
   logic              start_cmd;
   logic              stop_cmd;
   logic [4:0]        opc;
   logic [2:0]        fam;
   logic              b19;
   logic              indirect;
   logic              is_jump;
   logic              is_move;
   logic              is_mask;
   logic              is_insert;
   logic              is_load;
   logic              is_store;
   logic              is_cnt_jump;
   logic              is_loop_load;
   logic              is_mode_set;
   logic              known;
   logic              need_ind;
   logic              exec;
   logic [2:0]        csel;
   logic [5:0]        mask;
   logic [2:0]        ins_idx;
   logic [5:0]        ins_char;
   logic [5:0]        sel_char;
   logic [WORD_W-1:0] asm_ins;
   logic [5:0]        cmp_char;
   logic              match;
   ccx_state_t        go_seq;

   // ==========================================================
   // Storage port and character unit
   ccx_mem_port u_port (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .m           (mif.port),
      .mem_req_o   (mem_req_o),
      .mem_we_o    (mem_we_o),
      .mem_addr_o  (mem_addr_o),
      .mem_wdata_o (mem_wdata_o),
      .mem_ack_i   (mem_ack_i),
      .mem_rdata_i (mem_rdata_i)
   );

   ccx_char_unit u_char (
      .asm_i      (asm_reg),
      .idx_i      (ins_idx),
      .new_char_i (ins_char),
      .sel_char_o (sel_char),
      .asm_ins_o  (asm_ins)
   );

   // ==========================================================
   // Command decode
   assign mdone        = mif.done;
   assign opc          = {op_reg[OPC_LSB+3:OPC_LSB], op_reg[B19_BIT]};
   assign fam          = op_reg[FAM_LSB+2:FAM_LSB];
   assign b19          = op_reg[B19_BIT];
   assign indirect     = op_reg[IND_BIT];
   assign is_jump      = (fam == FAM_JUMP) && !b19;
   assign is_move      = (fam == FAM_MOVE) && b19;
   assign is_mask      = (fam == FAM_MASK) && b19;
   assign is_insert    = (fam == FAM_INSERT) && b19;
   assign is_load      = (opc == OPC_ASM_LOAD);
   assign is_store     = (opc == OPC_ASM_STORE);
   assign is_cnt_jump  = (opc == OPC_CNT_JUMP);
   assign is_loop_load = (opc == OPC_LOOP_LOAD);
   assign is_mode_set  = (opc == OPC_MODE_SET);
   assign known        = is_jump | is_move | is_mask | is_insert | is_load | is_store
                       | is_cnt_jump | is_loop_load | is_mode_set;
   assign need_ind     = indirect && !ind_done_reg && !is_insert;
   assign exec         = (state_reg == ST_DECODE) && !need_ind;
   assign csel         = word_cnt_reg[CSEL_LSB +: 3];
   assign mask         = word_cnt_reg[5:0];
   assign ins_idx      = (csel == 3'h0) ? 3'h6 : csel;
   assign ins_char     = (csel == 3'h0) ? mode_ind_o : ctl_cnt_reg;
   assign go_seq       = stop_pend_reg ? ST_IDLE : ST_FETCH;

   // Mask comparison source by count value.
   always_comb begin
      unique case (csel)
         3'h0:    cmp_char = check_reg;
         3'h7:    cmp_char = 6'h00;
         default: cmp_char = sel_char;
      endcase
   end
   assign match = (cmp_char == mask);

   // ==========================================================
   // Storage requests
   always_comb begin
      mif.req   = 1'b0;
      mif.we    = 1'b0;
      mif.addr  = addr_cnt_reg;
      mif.wdata = asm_reg;
      unique case (state_reg)
         ST_FETCH: begin
            mif.req  = 1'b1;
            mif.addr = cmd_cnt_reg;
         end
         ST_INDIR, ST_LOAD_RD: begin
            mif.req = 1'b1;
         end
         ST_STORE_WR: begin
            mif.req = 1'b1;
            mif.we  = 1'b1;
         end
         ST_MOVE_RD: begin
            mif.req  = 1'b1;
            mif.addr = cmd_cnt_reg;
         end
         ST_MOVE_WR: begin
            mif.req   = 1'b1;
            mif.we    = 1'b1;
            mif.wdata = data_reg;
         end
         default: begin
            mif.req = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE:     if (start_cmd) state_next = ST_FETCH;
         ST_FETCH:    if (mdone) state_next = ST_DECODE;
         ST_INDIR:    if (mdone) state_next = ST_DECODE;
         ST_LOAD_RD:  if (mdone) state_next = ST_LOAD_MOV;
         ST_LOAD_MOV: state_next = go_seq;
         ST_STORE_WR: if (mdone) state_next = go_seq;
         ST_MOVE_RD:  if (mdone) state_next = ST_MOVE_WR;
         ST_MOVE_WR: begin
            if (mdone) begin
               state_next = (word_cnt_reg == 15'h0001) ? go_seq : ST_MOVE_RD;
            end
         end
         ST_DECODE: begin
            if (need_ind) begin
               state_next = ST_INDIR;
            end else if (is_load) begin
               state_next = ST_LOAD_RD;
            end else if (is_store) begin
               state_next = ST_STORE_WR;
            end else if (is_move) begin
               state_next = (word_cnt_reg == '0) ? go_seq : ST_MOVE_RD;
            end else if (known) begin
               state_next = go_seq;
            end else begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         busy_o    <= 1'b0;
      end else begin
         state_reg <= state_next;
         busy_o    <= (state_next != ST_IDLE);
      end
   end

   // ==========================================================
   // Command counter
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cmd_cnt_reg <= '0;
      end else if (state_reg == ST_IDLE && start_cmd) begin
         cmd_cnt_reg <= start_addr_reg;
      end else if ((state_reg == ST_FETCH || state_reg == ST_MOVE_RD) && mdone) begin
         cmd_cnt_reg <= cmd_cnt_reg + 15'h0001;
      end else if (exec && is_jump) begin
         cmd_cnt_reg <= addr_cnt_reg;
      end else if (exec && is_cnt_jump && ctl_cnt_reg != 6'h00) begin
         cmd_cnt_reg <= addr_cnt_reg;
      end else if (exec && is_mask && match) begin
         cmd_cnt_reg <= addr_cnt_reg;
      end
   end

   // ==========================================================
   // Address and word counters, operation and indirect words
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         addr_cnt_reg <= '0;
         word_cnt_reg <= '0;
         op_reg       <= '0;
         ind_word_reg <= '0;
         ind_done_reg <= 1'b0;
      end else begin
         if (state_reg == ST_FETCH && mdone) begin
            op_reg       <= mif.rdata;
            word_cnt_reg <= mif.rdata[WC_LSB +: WC_W];
            addr_cnt_reg <= mif.rdata[ADDR_W-1:0];
            ind_done_reg <= 1'b0;
         end
         if (state_reg == ST_INDIR && mdone) begin
            ind_word_reg <= mif.rdata;
            addr_cnt_reg <= mif.rdata[ADDR_W-1:0];
            ind_done_reg <= 1'b1;
         end
         if (state_reg == ST_MOVE_WR && mdone) begin
            addr_cnt_reg <= addr_cnt_reg + 15'h0001;
            word_cnt_reg <= word_cnt_reg - 15'h0001;
         end
      end
   end

   // ==========================================================
   // Data register
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         data_reg <= '0;
      end else if ((state_reg == ST_LOAD_RD || state_reg == ST_MOVE_RD) && mdone) begin
         data_reg <= mif.rdata;
      end
   end

   // ==========================================================
   // Assembly register
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         asm_reg <= '0;
      end else if (state_reg == ST_LOAD_MOV) begin
         asm_reg <= data_reg;
      end else if (exec && is_insert && csel != 3'h7) begin
         asm_reg <= asm_ins;
      end else if (wr_hit && state_reg == ST_IDLE && avs_address_i == REG_ASM_LO) begin
         asm_reg[31:0] <= avs_writedata_i;
      end else if (wr_hit && state_reg == ST_IDLE && avs_address_i == REG_ASM_HI) begin
         asm_reg[35:32] <= avs_writedata_i[3:0];
      end
   end

   // ==========================================================
   // Control counter
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctl_cnt_reg <= '0;
      end else if (exec && is_loop_load) begin
         ctl_cnt_reg <= indirect ? ind_word_reg[5:0] : word_cnt_reg[5:0];
      end else if (exec && is_cnt_jump && ctl_cnt_reg != 6'h00) begin
         ctl_cnt_reg <= ctl_cnt_reg - 6'h01;
      end
   end

   // ==========================================================
   // Mode indicators
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         mode_ind_o <= MODE_RST;
      end else if (exec && is_mode_set) begin
         mode_ind_o <= indirect ? ind_word_reg[5:0] : op_reg[5:0];
      end
   end

   // ==========================================================
   // Software control, check condition and fault flag
   assign wr_hit    = avs_write_i && !avs_waitrequest_o;
   assign start_cmd = wr_hit && avs_address_i == REG_CTRL && avs_writedata_i[CTRL_START_BIT];
   assign stop_cmd  = wr_hit && avs_address_i == REG_CTRL && avs_writedata_i[CTRL_STOP_BIT];

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         start_addr_reg <= START_RST;
         check_reg      <= CHECK_RST;
      end else if (wr_hit && avs_address_i == REG_START) begin
         start_addr_reg <= avs_writedata_i[ADDR_W-1:0];
      end else if (wr_hit && avs_address_i == REG_CHECK) begin
         check_reg <= avs_writedata_i[5:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         unsup_reg     <= 1'b0;
         stop_pend_reg <= 1'b0;
      end else begin
         if (state_reg == ST_DECODE && !need_ind && !known) begin
            unsup_reg <= 1'b1;
         end else if (wr_hit && avs_address_i == REG_CTRL
                      && avs_writedata_i[CTRL_CLR_BIT]) begin
            unsup_reg <= 1'b0;
         end
         if (state_reg == ST_IDLE) begin
            stop_pend_reg <= 1'b0;
         end else if (stop_cmd) begin
            stop_pend_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Register bus responder
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else if (avs_waitrequest_o && (avs_read_i || avs_write_i)) begin
         avs_waitrequest_o <= 1'b0;
         unique case (avs_address_i)
            REG_CTRL:   avs_readdata_o <= {30'h0000_0000, unsup_reg, busy_o};
            REG_START:  avs_readdata_o <= {17'h0_0000, start_addr_reg};
            REG_STATUS: avs_readdata_o <= {2'h0, mode_ind_o, 2'h0, ctl_cnt_reg, 1'h0, cmd_cnt_reg};
            REG_ASM_LO: avs_readdata_o <= asm_reg[31:0];
            REG_ASM_HI: avs_readdata_o <= {28'h000_0000, asm_reg[35:32]};
            REG_CHECK:  avs_readdata_o <= {26'h000_0000, check_reg};
            default:    avs_readdata_o <= 32'h0000_0000;
         endcase
      end else begin
         avs_waitrequest_o <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// [hw/ccx_mem_if.sv]
// Storage request carrier between the executor core and its storage port.
`timescale 1ns/1ps
`default_nettype none
interface ccx_mem_if;
   import ccx_pkg::*;
   logic                req;
   logic                we;
   logic [ADDR_W-1:0]   addr;
   logic [WORD_W-1:0]   wdata;
   logic                done;
   logic [WORD_W-1:0]   rdata;
   modport core (output req, we, addr, wdata, input done, rdata);
   modport port (input req, we, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// [hw/ccx_mem_port.sv]
// Storage access port: holds one request on the storage pins until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module ccx_mem_port
   import ccx_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   // Core side
   ccx_mem_if.port                m,
   // Storage pins
   output logic                   mem_req_o,
   output logic                   mem_we_o,
   output logic [ADDR_W-1:0]      mem_addr_o,
   output logic [WORD_W-1:0]      mem_wdata_o,
   input  wire logic              mem_ack_i,
   input  wire logic [WORD_W-1:0] mem_rdata_i
);

   ccx_port_state_t   pst_reg;
   logic              done_reg;
   logic [WORD_W-1:0] rdata_reg;

   // ==========================================================
   // Request sequencing.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pst_reg     <= PS_IDLE;
         mem_req_o   <= 1'b0;
         mem_we_o    <= 1'b0;
         mem_addr_o  <= '0;
         mem_wdata_o <= '0;
         done_reg    <= 1'b0;
         rdata_reg   <= '0;
      end else begin
         unique case (pst_reg)
            PS_IDLE: begin
               if (m.req) begin
                  mem_req_o   <= 1'b1;
                  mem_we_o    <= m.we;
                  mem_addr_o  <= m.addr;
                  mem_wdata_o <= m.wdata;
                  pst_reg     <= PS_BUSY;
               end
            end
            PS_BUSY: begin
               if (mem_ack_i) begin
                  mem_req_o <= 1'b0;
                  mem_we_o  <= 1'b0;
                  rdata_reg <= mem_rdata_i;
                  done_reg  <= 1'b1;
                  pst_reg   <= PS_DONE;
               end
            end
            PS_DONE: begin
               done_reg <= 1'b0;
               pst_reg  <= PS_IDLE;
            end
            default: begin
               pst_reg <= PS_IDLE;
            end
         endcase
      end
   end

   assign m.done  = done_reg;
   assign m.rdata = rdata_reg;

endmodule
`default_nettype wire

// [hw/ccx_pkg.sv]
// Shared constants, opcodes and state types of the channel command executor.
package ccx_pkg;

   // ==========================================================
   // Word and field geometry
   localparam int WORD_W    = 36;
   localparam int ADDR_W    = 15;
   localparam int WC_W      = 15;
   localparam int CHAR_W    = 6;
   localparam int WC_LSB    = 18;
   localparam int IND_BIT   = 17;
   localparam int B19_BIT   = 16;
   localparam int CSEL_LSB  = 12;
   localparam int FAM_LSB   = 33;
   localparam int OPC_LSB   = 32;

   // ==========================================================
   // Register offsets (byte addresses) and bit positions
   localparam logic [4:0] REG_CTRL   = 5'h00;
   localparam logic [4:0] REG_START  = 5'h04;
   localparam logic [4:0] REG_STATUS = 5'h08;
   localparam logic [4:0] REG_ASM_LO = 5'h0C;
   localparam logic [4:0] REG_ASM_HI = 5'h10;
   localparam logic [4:0] REG_CHECK  = 5'h14;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_STOP_BIT  = 1;
   localparam int CTRL_CLR_BIT   = 2;

   // ==========================================================
   // Reset values
   localparam logic [5:0]  MODE_RST  = 6'h00;
   localparam logic [5:0]  CHECK_RST = 6'h00;
   localparam logic [14:0] START_RST = 15'h0000;

   // ==========================================================
   // Command codes: {S,1,2,3,19} and three-bit families {S,1,2}
   localparam logic [4:0] OPC_ASM_LOAD  = 5'h0C;
   localparam logic [4:0] OPC_ASM_STORE = 5'h0D;
   localparam logic [4:0] OPC_CNT_JUMP  = 5'h1A;
   localparam logic [4:0] OPC_LOOP_LOAD = 5'h1B;
   localparam logic [4:0] OPC_MODE_SET  = 5'h1C;
   localparam logic [2:0] FAM_MOVE      = 3'h0;
   localparam logic [2:0] FAM_JUMP      = 3'h1;
   localparam logic [2:0] FAM_MASK      = 3'h5;
   localparam logic [2:0] FAM_INSERT    = 3'h7;

   // ==========================================================
   // State types
   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0000,
      ST_FETCH    = 4'b0001,
      ST_DECODE   = 4'b0010,
      ST_INDIR    = 4'b0011,
      ST_LOAD_RD  = 4'b0100,
      ST_LOAD_MOV = 4'b0101,
      ST_STORE_WR = 4'b0110,
      ST_MOVE_RD  = 4'b0111,
      ST_MOVE_WR  = 4'b1000
   } ccx_state_t;

   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_BUSY = 2'b01,
      PS_DONE = 2'b10
   } ccx_port_state_t;

endpackage

// [sim/ccx_exec_checker.sv]
// Port checks of the channel command executor.
`timescale 1ns/1ps
`default_nettype none
module ccx_exec_checker
   import ccx_pkg::*;
(
   input wire logic              clk_sys_i,
   input wire logic              rst_i,
   input wire logic              avs_read_i,
   input wire logic              avs_write_i,
   input wire logic [31:0]       avs_readdata_o,
   input wire logic              avs_waitrequest_o,
   input wire logic              mem_req_o,
   input wire logic              mem_we_o,
   input wire logic [ADDR_W-1:0] mem_addr_o,
   input wire logic [WORD_W-1:0] mem_wdata_o,
   input wire logic              mem_ack_i,
   input wire logic [5:0]        mode_ind_o,
   input wire logic              busy_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   bus_wait_a:
      assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus access not answered after one wait cycle");
   wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   rdata_hold_a: assert property ($changed(avs_readdata_o) |-> !avs_waitrequest_o)
      else $error("read data changed outside an answer");
   mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_we_o)
      && $stable(mem_addr_o) && $stable(mem_wdata_o))
      else $error("storage request changed before acknowledge");
   mem_gap_a: assert property (mem_req_o && mem_ack_i |=> !mem_req_o [*2])
      else $error("storage request not dropped for two cycles");
   fetch_first_a: assert property ($rose(busy_o) |-> ##[0:4] (mem_req_o && !mem_we_o))
      else $error("run did not begin with a command fetch");
   mode_busy_a: assert property ($changed(mode_ind_o) |-> $past(busy_o))
      else $error("mode indicators changed while idle");
   mode_reset_a: assert property (disable iff (1'b0) rst_i |=> mode_ind_o == MODE_RST)
      else $error("reset did not clear mode indicators");
endmodule
bind ccx_exec ccx_exec_checker u_chk (.*);
`default_nettype wire

// [sim/ccx_mem_model.sv]
// Behavioural core storage answering requests with a varying delay.
`timescale 1ns/1ps
`default_nettype none
module ccx_mem_model
   import ccx_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              req_i,
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [WORD_W-1:0] wdata_i,
   output logic                   ack_o,
   output logic [WORD_W-1:0]      rdata_o
);
   logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [1:0]        cnt;
   logic [1:0]        lat;
   initial begin
      foreach (mem[i]) mem[i] = '0;
      ack_o = 1'b0;
      rdata_o = '0;
      cnt = 2'h0;
      lat = 2'h1;
   end
   always @(posedge clk_sys_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
         cnt <= cnt + 2'h1;
         if (cnt == lat) begin
            ack_o <= 1'b1;
            cnt <= 2'h0;
            lat <= (lat == 2'h3) ? 2'h1 : lat + 2'h1;
            if (we_i) mem[addr_i] <= wdata_i;
            else rdata_o <= mem[addr_i];
         end
      end
   end
endmodule
`default_nettype wire

// [sim/test_channel_control_command_executor.sv]
// Self-checking bench running two command programs through the executor.
`timescale 1ns/1ps
`default_nettype none
module test_channel_control_command_executor;
   import ccx_pkg::*;
   logic              clk_sys_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic              mem_req_o, mem_we_o, mem_ack_i, busy_o;
   logic [4:0]        avs_address_i;
   logic [31:0]       avs_writedata_i, avs_readdata_o, d;
   logic [ADDR_W-1:0] mem_addr_o;
   logic [WORD_W-1:0] mem_wdata_o, mem_rdata_i, e;
   logic [WORD_W-1:0] prog [21];
   logic [5:0]        mode_ind_o;
   int                fails, check_count, n;
   localparam logic [WORD_W-1:0] IND_F = 36'h0_0002_0000;
   ccx_exec DUT (.*);
   ccx_mem_model M (.clk_sys_i(clk_sys_i), .req_i(mem_req_o), .we_i(mem_we_o),
      .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   function automatic logic [WORD_W-1:0] mk(int f, int c, int m, int b, int y);
      return {3'(f), 3'(c), 6'h00, 6'(m), 1'b0, 1'(b), 1'b0, 15'(y)};
   endfunction
   task automatic chk(string s, logic [WORD_W-1:0] x, logic [WORD_W-1:0] g);
      check_count++;
      if (g !== x) begin
         fails++;
         $display("BAD %s expected %h seen %h", s, x, g);
      end
   endtask
   task automatic end_of_test;
      if (fails == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic bus(logic w, logic [4:0] a, logic [31:0] wd);
      int k;
      @(posedge clk_sys_i);
      avs_address_i <= a;
      avs_writedata_i <= wd;
      avs_write_i <= w;
      avs_read_i <= !w;
      k = 0;
      do begin
         @(posedge clk_sys_i);
         k++;
      end while (avs_waitrequest_o !== 1'b0 && k < 50);
      d = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (k >= 50) begin
         fails++;
         end_of_test();
      end
   endtask
   task automatic run(logic [31:0] s);
      bus(1'b1, REG_START, s);
      bus(1'b1, REG_CTRL, 32'h0000_0005);
      repeat (2) @(posedge clk_sys_i);
      for (n = 0; n < 3000 && busy_o !== 1'b0; n++) @(posedge clk_sys_i);
      if (n >= 3000) begin
         fails++;
         end_of_test();
      end
   endtask
   initial begin
      rst_i = 1'b1;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = '0;
      avs_writedata_i = '0;
      fails = 0;
      check_count = 0;
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      prog = '{mk(6,4,5,1,0), mk(0,0,2,1,64), 36'h9_ABCD_EF01, 36'h0_1357_9BDF,
         mk(6,4,0,0,22), 0, mk(3,0,0,0,64), mk(7,2,0,1,0), mk(5,2,4,1,26), 0,
         mk(7,0,0,0,37), mk(7,0,0,1,0), mk(7,7,0,1,0), mk(5,7,1,1,25), mk(5,0,10,1,32),
         0, mk(0,0,0,1,0), mk(1,0,0,0,35), 0, mk(3,0,0,1,80), 0};
      foreach (prog[i]) M.mem[16+i] = prog[i];
      M.mem[100] = mk(6,4,0,1,120) | IND_F;
      M.mem[101] = mk(7,0,0,0,121) | IND_F;
      M.mem[102] = mk(5,0,10,1,122) | IND_F;
      M.mem[110] = mk(3,0,0,1,90);
      M.mem[120] = 36'h5_5555_5547;
      M.mem[121] = 36'hF_FFFF_FF9A;
      M.mem[122] = 36'h0_0000_006E;
      bus(1'b1, REG_CHECK, 32'h0000_000A);
      run(32'h0000_0010);
      e = prog[2];
      e[29:24] = 6'h04;
      e[5:0] = 6'h25;
      chk("moved word 0", prog[2], M.mem[64]);
      chk("moved word 1", prog[3], M.mem[65]);
      chk("stored assembly", e, M.mem[80]);
      bus(1'b0, REG_ASM_LO, '0);
      chk("assembly low", 36'(e[31:0]), 36'(d));
      bus(1'b0, REG_STATUS, '0);
      chk("control counter", 36'(6'h04), 36'(d[21:16]));
      chk("command counter", 36'(15'h0025), 36'(d[14:0]));
      chk("mode status", 36'(6'h25), 36'(mode_ind_o));
      bus(1'b0, REG_CTRL, '0);
      chk("fault flag", 36'(2'h2), 36'(d[1:0]));
      bus(1'b0, 5'h18, 32'hFFFF_FFFF);
      chk("unmapped read", '0, 36'(d));
      run(32'h0000_0064);
      chk("indirect store", e, M.mem[90]);
      bus(1'b0, REG_STATUS, '0);
      chk("indirect count", 36'(6'h07), 36'(d[21:16]));
      chk("indirect mode", 36'(6'h1A), 36'(d[29:24]));
      chk("jump target", 36'(15'h0070), 36'(d[14:0]));
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      chk("mode after reset", '0, 36'(mode_ind_o));
      end_of_test();
   end
endmodule
`default_nettype wire
